// ==== iofa_bank.v ====
// io function assignment register bank with input and output mapping
//
// Notes on behaviour
// - The startup mode takes 0,1,2,3 or 5 and resets to 3 (pulse control).
// - Entering operation enable with local io control activates that mode.
// - Input codes 1 free, 6 and 7 permit motion, 8 limits speed.
// - Input codes 9 and 10 jog positive and negative, 11 picks jog speed.
// - Only input two also takes code 2, which resets the pending error.
// - Only input four also takes code 4, which commands a halt.
// - Output one codes 1 free, 2 no error, 3 ready, 4 direction blocked.
// - Output one codes 5 to 8 show position, speed windows and thresholds.
// - Output one code 9 shows halt acknowledge, 10 drives the brake.
// - A direct output write reaches output one only when it is free.
`timescale 1ns/1ps
`default_nettype none
`include "iofa_defs.vh"

module iofa_bank #(
  parameter NUM_IN = 5
) (
  // clock and reset
  input  wire        clk,
  input  wire        reset,
  // parameter access
  input  wire [15:0] parAddr,
  input  wire        parWrite,
  input  wire        parRead,
  input  wire [15:0] parWdata,
  output reg  [15:0] parRdata,
  output reg         parAck,
  output reg         parReject,
  // digital input pins: inputs 1,2,4,5,6
  input  wire [NUM_IN-1:0] inputPin,
  // drive state
  input  wire        operationEnableState,
  input  wire        commandInterfaceLocalIo,
  input  wire        noErrorIndication,
  input  wire        operatingReady,
  input  wire        directionBlockedIndication,
  input  wire        positionInWindow,
  input  wire        speedInWindow,
  input  wire        speedThresholdIndication,
  input  wire        currentThresholdIndication,
  input  wire        haltAcknowledge,
  input  wire        brakeRelease,
  // mode activation
  output reg         modeActivate,
  output reg  [15:0] activeMode,
  // motion requests
  output reg         positiveMotionPermit,
  output reg         negativeMotionPermit,
  output reg         speedLimitFunction,
  output reg         jogPositive,
  output reg         jogNegative,
  output reg         jogSpeedSelect,
  output reg         faultResetPulse,
  output reg         haltCommand,
  // digital output
  output reg         firstDigitalOutput
);

  // ****************************************
  // storage
  // ****************************************
  reg  [15:0]          startupMode_r;
  reg  [16*NUM_IN-1:0] inFunc_r;
  reg  [15:0]          outFunc_r;
  reg                  directOut_r;
  reg  [NUM_IN-1:0]    pinMeta_r;
  reg  [NUM_IN-1:0]    pinSync_r;
  reg                  opEnablePrev_r;
  reg                  faultLevelPrev_r;

  // ****************************************
  // code checks
  // ****************************************
  function modeValid;
    input [15:0] v;
    begin
      modeValid = (v == `IOFA_MODE_NONE) | (v == `IOFA_MODE_CURRENT) |
                  (v == `IOFA_MODE_SPEED) | (v == `IOFA_MODE_PULSE) |
                  (v == `IOFA_MODE_JOG);
    end
  endfunction

  function inValid;
    input [2:0]  slot;
    input [15:0] v;
    begin
      inValid = (v == `IOFA_IN_FREE) |
                ((v >= `IOFA_IN_POS) & (v <= `IOFA_IN_LIMIT)) |
                ((v >= `IOFA_IN_JOGP) & (v <= `IOFA_IN_JOG_SPEED_SELECT)) |
                ((slot == `IOFA_SLOT_IN2) & (v == `IOFA_IN_RESET)) |
                ((slot == `IOFA_SLOT_IN4) & (v == `IOFA_IN_HALT));
    end
  endfunction

  function outValid;
    input [15:0] v;
    begin
      outValid = (v >= `IOFA_OUT_FREE) & (v <= `IOFA_OUT_BRAKE);
    end
  endfunction

  // ****************************************
  // address decode
  // ****************************************
  reg        hitMode;
  reg        hitIn;
  reg        hitOut;
  reg        hitDirect;
  reg [2:0]  inSlot;
  reg        codeOk;
  reg [15:0] readValue;

  always @* begin
    hitMode   = (parAddr == `IOFA_ADDR_MODE);
    hitOut    = (parAddr == `IOFA_ADDR_OUT1);
    hitDirect = (parAddr == `IOFA_ADDR_DIRECT);
    hitIn     = 1'b1;
    inSlot    = 3'h0;
    case (parAddr)
      `IOFA_ADDR_IN1: inSlot = 3'h0;
      `IOFA_ADDR_IN2: inSlot = 3'h1;
      `IOFA_ADDR_IN4: inSlot = 3'h2;
      `IOFA_ADDR_IN5: inSlot = 3'h3;
      `IOFA_ADDR_IN6: inSlot = 3'h4;
      default:        hitIn  = 1'b0;
    endcase
    // refuse unlisted codes so the stored value survives
    if (hitMode) begin
      codeOk = modeValid(parWdata);
    end else if (hitIn) begin
      codeOk = inValid(inSlot, parWdata);
    end else if (hitOut) begin
      codeOk = outValid(parWdata);
    end else begin
      codeOk = hitDirect;
    end
    if (hitMode) begin
      readValue = startupMode_r;
    end else if (hitIn) begin
      readValue = inFunc_r[16*inSlot +: 16];
    end else if (hitOut) begin
      readValue = outFunc_r;
    end else if (hitDirect) begin
      readValue = {15'h0000, directOut_r};
    end else begin
      readValue = 16'h0000;
    end
  end

  // ****************************************
  // register writes and answers
  // ****************************************
  // write wins if both strobes come together
  always @(posedge clk) begin
    if (reset) begin
      startupMode_r <= `IOFA_RST_MODE;
      inFunc_r      <= {NUM_IN{`IOFA_RST_IN}};
      outFunc_r     <= `IOFA_RST_OUT;
      directOut_r   <= 1'b0;
      parRdata      <= 16'h0000;
      parAck        <= 1'b0;
      parReject     <= 1'b0;
    end else begin
      parAck    <= parWrite | parRead;
      parReject <= 1'b0;
      if (parWrite) begin
        if (!codeOk) begin
          parReject <= 1'b1;
        end else if (hitMode) begin
          startupMode_r <= parWdata;
        end else if (hitIn) begin
          inFunc_r[16*inSlot +: 16] <= parWdata;
        end else if (hitOut) begin
          outFunc_r <= parWdata;
        end else begin
          directOut_r <= parWdata[`IOFA_DIRECT_LO1];
        end
      end else if (parRead) begin
        parRdata  <= readValue;
        parReject <= ~(hitMode | hitIn | hitOut | hitDirect);
      end
    end
  end

  // ****************************************
  // input pin synchroniser
  // ****************************************
  always @(posedge clk) begin
    if (reset) begin
      pinMeta_r <= {NUM_IN{1'b0}};
      pinSync_r <= {NUM_IN{1'b0}};
    end else begin
      pinMeta_r <= inputPin;
      pinSync_r <= pinMeta_r;
    end
  end

  // ****************************************
  // per input decode
  // ****************************************
  wire [NUM_IN-1:0] posBlockV;
  wire [NUM_IN-1:0] negBlockV;
  wire [NUM_IN-1:0] limitV;
  wire [NUM_IN-1:0] jogPosV;
  wire [NUM_IN-1:0] jogNegV;
  wire [NUM_IN-1:0] jogFastV;
  wire [NUM_IN-1:0] resetV;
  wire [NUM_IN-1:0] haltV;

  genvar g;
  generate
    for (g = 0; g < NUM_IN; g = g + 1) begin : gIn
      iofa_input_decode uDec (
        .funcCode    (inFunc_r[16*g +: 16]),
        .inputLevel  (pinSync_r[g]),
        .posBlock    (posBlockV[g]),
        .negBlock    (negBlockV[g]),
        .speedLimit  (limitV[g]),
        .jogPos      (jogPosV[g]),
        .jogNeg      (jogNegV[g]),
        .jogFast     (jogFastV[g]),
        .faultReset  (resetV[g]),
        .haltRequest (haltV[g])
      );
    end
  endgenerate

  // ****************************************
  // motion requests
  // ****************************************
  // an unassigned permit leaves the direction free
  always @(posedge clk) begin
    if (reset) begin
      positiveMotionPermit <= 1'b0;
      negativeMotionPermit <= 1'b0;
      speedLimitFunction   <= 1'b0;
      jogPositive          <= 1'b0;
      jogNegative          <= 1'b0;
      jogSpeedSelect       <= 1'b0;
      haltCommand          <= 1'b0;
      faultResetPulse      <= 1'b0;
      faultLevelPrev_r     <= 1'b0;
    end else begin
      positiveMotionPermit <= ~|posBlockV;
      negativeMotionPermit <= ~|negBlockV;
      speedLimitFunction   <= |limitV;
      jogPositive          <= |jogPosV;
      jogNegative          <= |jogNegV;
      jogSpeedSelect       <= |jogFastV;
      haltCommand          <= |haltV;
      // one reset per activation, not a stream while held
      faultLevelPrev_r     <= |resetV;
      faultResetPulse      <= (|resetV) & ~faultLevelPrev_r;
    end
  end

  // ****************************************
  // startup mode activation
  // ****************************************
  always @(posedge clk) begin
    if (reset) begin
      opEnablePrev_r <= 1'b0;
      modeActivate   <= 1'b0;
      activeMode     <= `IOFA_MODE_NONE;
    end else begin
      opEnablePrev_r <= operationEnableState;
      modeActivate   <= 1'b0;
      if (operationEnableState & ~opEnablePrev_r &
          commandInterfaceLocalIo) begin
        modeActivate <= 1'b1;
        activeMode   <= startupMode_r;
      end
    end
  end

  // ****************************************
  // first digital output
  // ****************************************
  reg outNxt;

  always @* begin
    case (outFunc_r)
      `IOFA_OUT_FREE:    outNxt = directOut_r;
      `IOFA_OUT_NOERR:   outNxt = noErrorIndication;
      `IOFA_OUT_READY:   outNxt = operatingReady;
      `IOFA_OUT_BLOCKED: outNxt = directionBlockedIndication;
      `IOFA_OUT_POSWIN:  outNxt = positionInWindow;
      `IOFA_OUT_SPDWIN:  outNxt = speedInWindow;
      `IOFA_OUT_SPDTHR:  outNxt = speedThresholdIndication;
      `IOFA_OUT_CURTHR:  outNxt = currentThresholdIndication;
      `IOFA_OUT_HALTACK: outNxt = haltAcknowledge;
      `IOFA_OUT_BRAKE:   outNxt = brakeRelease;
      default:           outNxt = 1'b0;
    endcase
  end

  always @(posedge clk) begin
    if (reset) begin
      firstDigitalOutput <= 1'b0;
    end else begin
      firstDigitalOutput <= outNxt;
    end
  end

endmodule // iofa_bank

`default_nettype wire

// ==== iofa_bank_props.sv ====
// assertion checker for the io function assignment bank
`timescale 1ns/1ps
`default_nettype none

module iofa_bank_props #(
  parameter NUM_IN = 5
) (
  // clock and reset
  input wire logic        clk,
  input wire logic        reset,
  // parameter access
  input wire logic [15:0] parAddr,
  input wire logic        parWrite,
  input wire logic        parRead,
  input wire logic [15:0] parWdata,
  input wire logic        parAck,
  input wire logic        parReject,
  // drive state and results
  input wire logic        operationEnableState,
  input wire logic        commandInterfaceLocalIo,
  input wire logic        modeActivate,
  input wire logic        faultResetPulse
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  wire logic wrMode = parWrite && parAddr == 16'h0506;
  wire logic wrOut  = parWrite && parAddr == 16'h0712;
  wire logic wrIn   = parWrite && parAddr inside
    {16'h0702, 16'h0704, 16'h0708, 16'h070A, 16'h070C};

  // ****************
  // properties
  // ****************
  a_ack_follows: assert property ((parWrite || parRead) |=> parAck)
    else $error("no ack after request");
  a_reject_has_ack: assert property (parReject |-> parAck)
    else $error("reject without ack");
  a_mode_range: assert property (wrMode &&
    (parWdata > 16'h0005 || parWdata == 16'h0004) |=> parReject)
    else $error("bad mode taken");
  a_mode_ok: assert property (wrMode && parWdata == 16'h0003 |=>
    !parReject) else $error("pulse mode refused");
  a_in_motion: assert property (wrIn && parWdata inside
    {16'h0006, 16'h0007, 16'h0008} |=> parAck && !parReject)
    else $error("motion code refused");
  a_in_jog: assert property (wrIn && parWdata inside
    {16'h0009, 16'h000A, 16'h000B} |=> parAck && !parReject)
    else $error("jog code refused");
  a_reset_only_in2: assert property (wrIn && parAddr != 16'h0704 &&
    parWdata == 16'h0002 |=> parReject) else $error("code 2 taken");
  a_halt_only_in4: assert property (wrIn && parAddr != 16'h0708 &&
    parWdata == 16'h0004 |=> parReject) else $error("code 4 taken");
  a_out_range: assert property (wrOut &&
    (parWdata == 16'h0000 || parWdata > 16'h000A) |=> parReject)
    else $error("bad output code taken");
  a_activate_local: assert property ($rose(operationEnableState) &&
    commandInterfaceLocalIo |=> modeActivate) else $error("no activation");
  a_activate_remote: assert property ($rose(operationEnableState) &&
    !commandInterfaceLocalIo |=> !modeActivate) else $error("activated");
  a_fault_pulse: assert property (faultResetPulse |=> !faultResetPulse)
    else $error("fault reset longer than a cycle");

  c_activate: cover property (modeActivate);
  c_reject: cover property (parReject);
  c_fault: cover property (faultResetPulse);
endmodule // iofa_bank_props

bind iofa_bank iofa_bank_props #(.NUM_IN(NUM_IN)) u_props (
  .clk(clk), .reset(reset), .parAddr(parAddr), .parWrite(parWrite),
  .parRead(parRead), .parWdata(parWdata), .parAck(parAck),
  .parReject(parReject), .operationEnableState(operationEnableState),
  .commandInterfaceLocalIo(commandInterfaceLocalIo),
  .modeActivate(modeActivate), .faultResetPulse(faultResetPulse));
`default_nettype wire

// ==== iofa_defs.vh ====
// constants for the io function assignment bank
`ifndef IOFA_DEFS_VH
`define IOFA_DEFS_VH

// ****************************************
// parameter addresses
// ****************************************
`define IOFA_ADDR_MODE     16'h0506
`define IOFA_ADDR_IN1      16'h0702
`define IOFA_ADDR_IN2      16'h0704
`define IOFA_ADDR_IN4      16'h0708
`define IOFA_ADDR_IN5      16'h070A
`define IOFA_ADDR_IN6      16'h070C
`define IOFA_ADDR_OUT1     16'h0712
`define IOFA_ADDR_DIRECT   16'h0822

// ****************************************
// reset values
// ****************************************
`define IOFA_RST_MODE      16'h0003
`define IOFA_RST_IN        16'h0001
`define IOFA_RST_OUT       16'h0001
`define IOFA_RST_DIRECT    16'h0000

// ****************************************
// startup mode codes
// ****************************************
`define IOFA_MODE_NONE     16'h0000
`define IOFA_MODE_CURRENT  16'h0001
`define IOFA_MODE_SPEED    16'h0002
`define IOFA_MODE_PULSE    16'h0003
`define IOFA_MODE_JOG      16'h0005

// ****************************************
// input function codes
// ****************************************
`define IOFA_IN_FREE       16'h0001
`define IOFA_IN_RESET      16'h0002
`define IOFA_IN_HALT       16'h0004
`define IOFA_IN_POS        16'h0006
`define IOFA_IN_NEG        16'h0007
`define IOFA_IN_LIMIT      16'h0008
`define IOFA_IN_JOGP       16'h0009
`define IOFA_IN_JOG_DIRECTION_FUNCTION       16'h000A
`define IOFA_IN_JOG_SPEED_SELECT       16'h000B

// ****************************************
// output function codes
// ****************************************
`define IOFA_OUT_FREE      16'h0001
`define IOFA_OUT_NOERR     16'h0002
`define IOFA_OUT_READY     16'h0003
`define IOFA_OUT_BLOCKED   16'h0004
`define IOFA_OUT_POSWIN    16'h0005
`define IOFA_OUT_SPDWIN    16'h0006
`define IOFA_OUT_SPDTHR    16'h0007
`define IOFA_OUT_CURTHR    16'h0008
`define IOFA_OUT_HALTACK   16'h0009
`define IOFA_OUT_BRAKE     16'h000A

// ****************************************
// field positions and slots
// ****************************************
`define IOFA_DIRECT_LO1    0
`define IOFA_SLOT_IN2      3'h1
`define IOFA_SLOT_IN4      3'h2

`endif

// ==== iofa_input_decode.v ====
// decoder of one programmable input against its function code
`timescale 1ns/1ps
`default_nettype none
`include "iofa_defs.vh"

module iofa_input_decode (
  // function and level
  input  wire [15:0] funcCode,
  input  wire        inputLevel,
  // decoded requests
  output wire        posBlock,
  output wire        negBlock,
  output wire        speedLimit,
  output wire        jogPos,
  output wire        jogNeg,
  output wire        jogFast,
  output wire        faultReset,
  output wire        haltRequest
);

  // ****************************************
  // decode
  // ****************************************
  // a permit input that is low blocks its direction
  assign posBlock    = (funcCode == `IOFA_IN_POS) & ~inputLevel;
  assign negBlock    = (funcCode == `IOFA_IN_NEG) & ~inputLevel;
  assign speedLimit  = (funcCode == `IOFA_IN_LIMIT) & inputLevel;
  assign jogPos      = (funcCode == `IOFA_IN_JOGP) & inputLevel;
  assign jogNeg      = (funcCode == `IOFA_IN_JOG_DIRECTION_FUNCTION) & inputLevel;
  assign jogFast     = (funcCode == `IOFA_IN_JOG_SPEED_SELECT) & inputLevel;
  // only reachable where the code was accepted for this slot
  assign faultReset  = (funcCode == `IOFA_IN_RESET) & inputLevel;
  assign haltRequest = (funcCode == `IOFA_IN_HALT) & inputLevel;

endmodule // iofa_input_decode

`default_nettype wire

// ==== iofa_master_model.sv ====
// fieldbus master model driving the parameter port
`timescale 1ns/1ps
`default_nettype none

module iofa_master_model (
  // clock
  input  wire logic        clk,
  // parameter access
  output var  logic [15:0] parAddr,
  output var  logic        parWrite,
  output var  logic        parRead,
  output var  logic [15:0] parWdata
);
  // expected answers, {read, reject, data}
  logic [17:0] expQ[$];

  initial begin
    parAddr  = 16'h0000;
    parWrite = 1'b0;
    parRead  = 1'b0;
    parWdata = 16'h0000;
  end

  // one request; a random idle gap gives slow and prompt traffic
  task automatic xfer(input logic rd, input logic [15:0] a,
                      input logic [15:0] d, input logic rej,
                      input logic [15:0] rdat);
    repeat ($urandom_range(2, 0)) @(posedge clk);
    @(posedge clk);
    parRead  <= rd;
    parWrite <= !rd;
    parAddr  <= a;
    parWdata <= d;
    expQ.push_back({rd, rej, rdat});
    @(posedge clk);
    parRead  <= 1'b0;
    parWrite <= 1'b0;
    // released lines flip so stale values are never trusted
    parAddr  <= ~a;
    parWdata <= ~d;
  endtask
endmodule // iofa_master_model
`default_nettype wire

// ==== tb_io_function_assignment_bank.sv ====
// self-checking testbench for the io function assignment bank
`timescale 1ns/1ps
`default_nettype none

module tb_io_function_assignment_bank;
  logic        clk;
  logic        reset;
  logic [4:0]  pin;
  logic        oe;
  logic        localIo;
  logic [8:0]  st;
  logic [4:0]  p;
  logic [6:0]  expv;
  logic [15:0] cnt;
  logic [17:0] e;
  wire  [15:0] parAddr;
  wire  [15:0] parWdata;
  wire  [15:0] parRdata;
  wire         parWrite;
  wire         parRead;
  wire         parAck;
  wire         parReject;
  wire         modeActivate;
  wire  [15:0] activeMode;
  wire  [6:0]  req;
  wire         faultResetPulse;
  wire         dout;
  int          fail_count;
  int          num_checks;
  logic [15:0] addrs[7] = '{16'h0506, 16'h0702, 16'h0704, 16'h0708,
                            16'h070A, 16'h070C, 16'h0712};
  logic [15:0] codes[7] = '{16'h6, 16'h7, 16'h8, 16'h9, 16'hA, 16'hB, 16'h4};

  iofa_master_model m (.clk(clk), .parAddr(parAddr), .parWrite(parWrite),
    .parRead(parRead), .parWdata(parWdata));
  iofa_bank #(.NUM_IN(5)) dut (
    .clk(clk), .reset(reset), .parAddr(parAddr), .parWrite(parWrite),
    .parRead(parRead), .parWdata(parWdata), .parRdata(parRdata),
    .parAck(parAck), .parReject(parReject), .inputPin(pin),
    .operationEnableState(oe), .commandInterfaceLocalIo(localIo),
    .noErrorIndication(st[0]), .operatingReady(st[1]),
    .directionBlockedIndication(st[2]), .positionInWindow(st[3]),
    .speedInWindow(st[4]), .speedThresholdIndication(st[5]),
    .currentThresholdIndication(st[6]), .haltAcknowledge(st[7]),
    .brakeRelease(st[8]), .modeActivate(modeActivate),
    .activeMode(activeMode), .positiveMotionPermit(req[0]),
    .negativeMotionPermit(req[1]), .speedLimitFunction(req[2]),
    .jogPositive(req[3]), .jogNegative(req[4]), .jogSpeedSelect(req[5]),
    .haltCommand(req[6]), .faultResetPulse(faultResetPulse),
    .firstDigitalOutput(dout));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // ****************
  // answer watcher
  // ****************
  always @(posedge clk) begin
    if (parAck === 1'b1) begin
      if (m.expQ.size() == 0) chk(16'hDEAD, 16'h0000);
      else begin
        e = m.expQ.pop_front();
        chk({15'h0, parReject}, {15'h0, e[16]});
        if (e[17]) chk(parRdata, e[15:0]);
      end
    end
  end

  task automatic wr(input logic [15:0] a, input logic [15:0] d,
                    input logic rej);
    m.xfer(1'b0, a, d, rej, 16'h0000);
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] x,
                    input logic rej);
    m.xfer(1'b1, a, 16'h0000, rej, x);
  endtask
  task automatic doReset();
    reset <= 1'b1;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
  endtask
  // every code 0..15 plus one with upper bits set; refused ones keep value
  task automatic tryCodes(input logic [15:0] a, input logic [15:0] ok,
                          input logic [15:0] cur);
    for (int c = 0; c < 16; c++) begin
      wr(a, 16'(c), !ok[c]);
      if (ok[c]) cur = 16'(c);
      rd(a, cur, 1'b0);
    end
    wr(a, {8'($urandom_range(255, 1)), 8'h01}, 1'b1);
    rd(a, cur, 1'b0);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ****************
  // tests
  // ****************
  initial begin
    reset = 1'b1;
    pin = 5'h00;
    oe = 1'b0;
    localIo = 1'b0;
    st = 9'h000;
    fail_count = 0;
    num_checks = 0;
    void'($urandom(32'hCB86));
    doReset();
    foreach (addrs[i]) rd(addrs[i], i == 0 ? 16'h3 : 16'h1, 1'b0);
    rd(16'h0822, 16'h0000, 1'b0);
    rd(16'h0700, 16'h0000, 1'b1);
    wr(16'h0600, 16'h0001, 1'b1);
    $display("test reset values done");
    tryCodes(addrs[0], 16'h002F, 16'h0003);
    tryCodes(addrs[1], 16'h0FC2, 16'h0001);
    tryCodes(addrs[2], 16'h0FC6, 16'h0001);
    tryCodes(addrs[3], 16'h0FD2, 16'h0001);
    tryCodes(addrs[4], 16'h0FC2, 16'h0001);
    tryCodes(addrs[5], 16'h0FC2, 16'h0001);
    tryCodes(addrs[6], 16'h07FE, 16'h0001);
    $display("test code acceptance done");
    // second reset puts every function back to free
    doReset();
    foreach (addrs[i]) rd(addrs[i], i == 0 ? 16'h3 : 16'h1, 1'b0);
    for (int i = 0; i < 5; i++) begin
      foreach (codes[k]) begin
        if (codes[k] == 16'h4 && i != 2) continue;
        wr(addrs[i+1], codes[k], 1'b0);
        for (int v = 0; v < 2; v++) begin
          p = 5'($urandom);
          p[i] = v[0];
          expv = 7'h03;
          expv[codes[k] == 16'h4 ? 6 : codes[k] - 6] = v[0];
          @(posedge clk);
          pin <= p;
          repeat (4) @(posedge clk);
          #1 chk(16'(req), 16'(expv));
        end
        wr(addrs[i+1], 16'h1, 1'b0);
      end
    end
    $display("test input functions done");
    wr(addrs[2], 16'h2, 1'b0);
    @(posedge clk);
    pin <= 5'h00;
    repeat (4) @(posedge clk);
    pin <= 5'h02;
    cnt = 0;
    repeat (8) begin
      @(posedge clk);
      #1 cnt = cnt + 16'(faultResetPulse);
    end
    chk(cnt, 16'h1);
    $display("test fault reset done");
    for (int c = 2; c < 11; c++) begin
      wr(addrs[6], 16'(c), 1'b0);
      repeat (2) begin
        @(posedge clk);
        st <= 9'($urandom);
        repeat (3) @(posedge clk);
        #1 chk(16'(dout), 16'(st[c-2]));
      end
    end
    wr(addrs[6], 16'h1, 1'b0);
    wr(16'h0822, 16'h0001, 1'b0);
    repeat (3) @(posedge clk);
    #1 chk(16'(dout), 16'h1);
    @(posedge clk);
    st <= 9'h000;
    wr(addrs[6], 16'h2, 1'b0);
    wr(16'h0822, 16'hFFFF, 1'b0);
    rd(16'h0822, 16'h0001, 1'b0);
    repeat (3) @(posedge clk);
    #1 chk(16'(dout), 16'h0);
    $display("test output functions done");
    wr(addrs[0], 16'h5, 1'b0);
    for (int v = 1; v >= 0; v--) begin
      @(posedge clk);
      localIo <= v[0];
      oe <= 1'b1;
      cnt = 0;
      repeat (4) begin
        @(posedge clk);
        #1 cnt = cnt + 16'(modeActivate);
      end
      chk(cnt, 16'(v));
      @(posedge clk);
      oe <= 1'b0;
    end
    chk(activeMode, 16'h5);
    $display("test mode activation done");
    repeat (3) @(posedge clk);
    end_of_test();
  end

  // watchdog, far beyond the fewer than two thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    end_of_test();
  end
endmodule // tb_io_function_assignment_bank
`default_nettype wire
